/* logic/aem_consts.vh */
/*
 * constants for the extended-mode audio register bank: port offsets,
 * extension register numbers, field positions, reset values, codes.
 * assumes inclusion by bare name from the design file.
 */
`ifndef AEM_CONSTS_VH
`define AEM_CONSTS_VH

// ****************************************
// host port offsets
// ****************************************
`define AEM_PORT_READ_DATA 12'h00A
`define AEM_PORT_READ_STATUS 12'h00E
`define AEM_PORT_COMMAND 12'h00C
`define AEM_PORT_SYN_IDX0 12'h388
`define AEM_PORT_SYN_DAT0 12'h389
`define AEM_PORT_SYN_IDX1 12'h38A
`define AEM_PORT_SYN_DAT1 12'h38B

// ****************************************
// extension register numbers
// ****************************************
`define AEM_REG_RELOAD_LO 8'hA4
`define AEM_REG_RELOAD_HI 8'hA5
`define AEM_REG_PROG_TYPE 8'hA8
`define AEM_REG_INT_CTRL 8'hB1
`define AEM_REG_DMA_CTRL 8'hB2
`define AEM_REG_IN_GAIN 8'hB4
`define AEM_REG_PB_INIT 8'hB6
`define AEM_REG_FMT_CFG 8'hB7
`define AEM_CMD_READ 8'hC0

// ****************************************
// field positions and masks
// ****************************************
`define AEM_PT_MONITOR 3
`define AEM_PT_MASK 8'h0B
`define AEM_IC_CPU_IRQ 7
`define AEM_IC_OVF_IRQ 6
`define AEM_IC_HALF_IRQ 5
`define AEM_IC_IRQ_EN 4
`define AEM_DC_GAME_REQ 7
`define AEM_DC_EXT_REQ 6
`define AEM_DC_GAME_EN 5
`define AEM_DC_WR_MASK 8'hF0
`define AEM_PB_MASK 8'h80
`define AEM_RDA_BIT 7

// ****************************************
// codes and reset values
// ****************************************
`define AEM_PT_MONO 2'h2
`define AEM_PT_STEREO 2'h1
`define AEM_SEL_A 4'h5
`define AEM_SEL_B 4'hA
`define AEM_SEL_C 4'hF
`define AEM_SEL_OTHER 4'h0
`define AEM_INT_CTRL_RST 8'h05
`define AEM_FMT_HDR_UNS 8'h51
`define AEM_FMT_HDR_SGN 8'h71
`define AEM_FMT_STEREO 3
`define AEM_FMT_WIDE 2
`define AEM_FMT_SIGNED 5
`define AEM_SYN_REGS 243
`define AEM_SYN_BANK_SZ 256
`define AEM_SYN_STATUS_RST 8'h00

`endif

/* logic/aem_fifo.v */
/*
 * synchronous fifo with valid/ready on both sides.
 * assumes one clock and an active low asynchronous reset.
 */
`timescale 1ns/100ps
module aem_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // clock and reset
  input wire clk_sys,
  input wire reset_n,
  // fill side
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  // drain side
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData,
  // level
  output wire [AW:0] level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_ff;
  reg [AW-1:0] rdPtr_ff;
  reg [AW:0] count_ff;
  wire push;
  wire pop;

  assign inReady = (count_ff != DEPTH[AW:0]);
  assign outValid = (count_ff != {(AW+1){1'b0}});
  assign outData = mem[rdPtr_ff];
  assign level = count_ff;
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  always @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr_ff] <= inData;
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_ff <= {AW{1'b0}};
      rdPtr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wrPtr_ff <= wrPtr_ff + 1'b1;
      end
      if (pop) begin
        rdPtr_ff <= rdPtr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule

/* logic/aem_register_bank.v */
/*
 * extended-mode register bank of a sound controller: command port with
 * extension register write/read, dma transfer counter, request and
 * interrupt gating, format decode, indexed synthesizer register file,
 * and a playback byte fifo between dma and the converter.
 * assumes a synchronous host strobe interface on clk_sys; the dma
 * acknowledge and half-empty sources come from logic on the same clock.
 */
`timescale 1ns/100ps
`include "aem_consts.vh"

// Contract
// R1 - reload transfer counter from reload value at start and each overflow
// R2 - reload low byte from A4, high byte from A5
// R3 - counter increments once per byte moved by dma
// R4 - program type 10 mono, 01 stereo
// R5 - bit 3 of program type enables record monitor
// R6 - interrupt control bit 7 low suppresses processor interrupt
// R7 - counter overflow interrupt only with bit 6 set
// R8 - fifo half-empty interrupt in extended mode only with bit 5
// R9 - bit 4 low blocks every interrupt source
// R10 - four-bit select routes interrupt to line 5, 7, 10 or other
// R11 - host keeps game-compatible request bit clear in extended mode
// R12 - extended dma requests only with dma control bit 6
// R13 - game mode dma requests only with dma control bit 5
// R14 - dma channel reported in read-only four-bit field
// R15 - low nibble left gain, high nibble right gain
// R16 - B6 sets playback sign only: 80 unsigned, 00 signed
// R17 - host writes two bytes to B7: header then format byte
// R18 - second B7 byte decodes channels, width and sign
// R19 - host writes index to 388 or 38A, data to 389 or 38B
// R20 - last synthesizer index is kept for later data writes
// R21 - synthesizer ports write-only except status read at 388
// R22 - 243 synthesizer control registers in two banks
// R23 - extension write: register number then data to command port
// R24 - extension read: C0, number, poll data-available, read value
// R25 - reserved bits read zero and ignore writes
module aem_register_bank #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4,
  parameter [3:0] DMA_CHAN_CODE = 4'h5
) (
  // clock and reset
  input wire clk_sys,
  input wire reset_n,
  // host port access
  input wire [11:0] hostAddr,
  input wire hostWr,
  input wire hostRd,
  input wire [7:0] hostWrData,
  output reg [7:0] hostRdData,
  // mode and dma
  input wire extMode,
  input wire dmaAck,
  input wire [7:0] dmaData,
  output reg dmaReq,
  // converter side of the playback fifo
  output reg [7:0] pbData,
  output reg pbValid,
  input wire pbReady,
  // interrupt
  input wire halfEmptyEvt,
  output reg irqLine5,
  output reg irqLine7,
  output reg irqLine10,
  output reg irqLineOther,
  // decoded configuration
  output reg monoMode,
  output reg stereoMode,
  output reg recMonitor,
  output reg [3:0] gainLeft,
  output reg [3:0] gainRight,
  output reg pbUnsigned,
  output reg fmtStereo,
  output reg fmtWide,
  output reg fmtSigned,
  output reg [7:0] synStatusOut
);
  // ****************************************
  // state
  // ****************************************
  localparam CMD_IDLE = 2'h0;
  localparam CMD_DATA = 2'h1;
  localparam CMD_RDNUM = 2'h2;

  reg [1:0] cmdState_ff;
  reg [1:0] nxt_cmdState;
  reg [7:0] cmdReg_ff;
  reg [7:0] reloadLo_ff;
  reg [7:0] reloadHi_ff;
  reg [7:0] progType_ff;
  reg [7:0] intCtrl_ff;
  reg [7:0] dmaCtrl_ff;
  reg [7:0] inGain_ff;
  reg [7:0] pbInit_ff;
  reg [7:0] fmtHdr_ff;
  reg [7:0] fmtByte_ff;
  reg fmtSecond_ff;
  reg [7:0] readBack_ff;
  reg readAvail_ff;
  reg [15:0] xferCount_ff;
  reg started_ff;
  reg [7:0] synIdx_ff;
  reg synBank_ff;
  reg [7:0] synStatus_ff;
  reg [7:0] synMem [0:2*`AEM_SYN_BANK_SZ-1];
  reg [7:0] extRead;

  wire isCmd;
  wire cmdWr;
  wire xferByte;
  wire overflow;
  wire irqPending;
  wire fifoInReady;
  wire fifoOutValid;
  wire [7:0] fifoOutData;
  wire fifoPop;

  assign isCmd = (hostAddr == `AEM_PORT_COMMAND);
  assign cmdWr = hostWr & isCmd;
  assign fifoPop = pbReady | ~pbValid;
  // R3 byte moved count
  assign xferByte = dmaReq & dmaAck & fifoInReady;
  assign overflow = xferByte & (xferCount_ff == 16'hFFFF);

  // ****************************************
  // playback fifo
  // ****************************************
  aem_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .inValid(xferByte),
    .inReady(fifoInReady),
    .inData(dmaData),
    .outValid(fifoOutValid),
    .outReady(fifoPop),
    .outData(fifoOutData),
    .level()
  );

  // ****************************************
  // command port sequencing
  // ****************************************
  // R23 number then data
  always @* begin
    nxt_cmdState = cmdState_ff;
    case (cmdState_ff)
      CMD_IDLE: begin
        if (cmdWr) begin
          if (hostWrData == `AEM_CMD_READ) begin
            nxt_cmdState = CMD_RDNUM;
          end else begin
            nxt_cmdState = CMD_DATA;
          end
        end
      end
      CMD_DATA: begin
        if (cmdWr) begin
          nxt_cmdState = CMD_IDLE;
        end
      end
      CMD_RDNUM: begin
        if (cmdWr) begin
          nxt_cmdState = CMD_IDLE;
        end
      end
      default: begin
        nxt_cmdState = CMD_IDLE;
      end
    endcase
  end

  // R25 reserved bits zero
  always @* begin
    case (hostWrData)
      `AEM_REG_RELOAD_LO: extRead = reloadLo_ff;
      `AEM_REG_RELOAD_HI: extRead = reloadHi_ff;
      `AEM_REG_PROG_TYPE: extRead = progType_ff;
      `AEM_REG_INT_CTRL: extRead = intCtrl_ff;
      // R14 channel read-only
      `AEM_REG_DMA_CTRL: extRead = {dmaCtrl_ff[7:4], DMA_CHAN_CODE};
      `AEM_REG_IN_GAIN: extRead = inGain_ff;
      `AEM_REG_PB_INIT: extRead = pbInit_ff;
      `AEM_REG_FMT_CFG: extRead = fmtByte_ff;
      default: extRead = 8'h00;
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cmdState_ff <= CMD_IDLE;
      cmdReg_ff <= 8'h00;
      reloadLo_ff <= 8'h00;
      reloadHi_ff <= 8'h00;
      progType_ff <= 8'h00;
      intCtrl_ff <= `AEM_INT_CTRL_RST;
      dmaCtrl_ff <= 8'h00;
      inGain_ff <= 8'h00;
      pbInit_ff <= 8'h00;
      fmtHdr_ff <= 8'h00;
      fmtByte_ff <= 8'h00;
      fmtSecond_ff <= 1'b0;
      readBack_ff <= 8'h00;
      readAvail_ff <= 1'b0;
    end else begin
      cmdState_ff <= nxt_cmdState;
      if (cmdWr && cmdState_ff == CMD_IDLE) begin
        cmdReg_ff <= hostWrData;
      end
      // R24 read-back data available
      if (cmdWr && cmdState_ff == CMD_RDNUM) begin
        readBack_ff <= extRead;
        readAvail_ff <= 1'b1;
      end else if (hostRd && hostAddr == `AEM_PORT_READ_DATA) begin
        readAvail_ff <= 1'b0;
      end
      if (cmdWr && cmdState_ff == CMD_DATA) begin
        case (cmdReg_ff)
          // R2 reload byte lanes
          `AEM_REG_RELOAD_LO: reloadLo_ff <= hostWrData;
          `AEM_REG_RELOAD_HI: reloadHi_ff <= hostWrData;
          `AEM_REG_PROG_TYPE: progType_ff <= hostWrData & `AEM_PT_MASK;
          `AEM_REG_INT_CTRL: intCtrl_ff <= hostWrData;
          `AEM_REG_DMA_CTRL: dmaCtrl_ff <= hostWrData & `AEM_DC_WR_MASK;
          `AEM_REG_IN_GAIN: inGain_ff <= hostWrData;
          // R16 sign setup only
          `AEM_REG_PB_INIT: pbInit_ff <= hostWrData & `AEM_PB_MASK;
          // R17 two-byte load
          `AEM_REG_FMT_CFG: begin
            if (fmtSecond_ff) begin
              fmtByte_ff <= hostWrData;
            end else begin
              fmtHdr_ff <= hostWrData;
            end
            fmtSecond_ff <= ~fmtSecond_ff;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ****************************************
  // transfer counter and dma request
  // ****************************************
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      xferCount_ff <= 16'h0000;
      started_ff <= 1'b0;
      dmaReq <= 1'b0;
    end else begin
      // R1 reload while idle and on overflow
      // holding the reload while idle lets the first byte count as well
      if (overflow || (!started_ff && !xferByte)) begin
        xferCount_ff <= {reloadHi_ff, reloadLo_ff};
      end else if (xferByte) begin
        xferCount_ff <= xferCount_ff + 16'h0001;
      end
      if (xferByte) begin
        started_ff <= 1'b1;
      end
      // R12 extended request gate
      // R13 game request gate
      // R11 game bit assumed clear
      if (extMode) begin
        dmaReq <= dmaCtrl_ff[`AEM_DC_EXT_REQ] & fifoInReady;
      end else begin
        dmaReq <= dmaCtrl_ff[`AEM_DC_GAME_EN] & fifoInReady;
      end
      if (!dmaCtrl_ff[`AEM_DC_EXT_REQ] && !dmaCtrl_ff[`AEM_DC_GAME_EN]) begin
        started_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // interrupt gating and routing
  // ****************************************
  // R6 processor interrupt gate
  // R7 overflow source
  // R8 half-empty source
  // R9 global enable
  assign irqPending = intCtrl_ff[`AEM_IC_CPU_IRQ] &
    intCtrl_ff[`AEM_IC_IRQ_EN] &
    ((overflow & intCtrl_ff[`AEM_IC_OVF_IRQ]) |
    (halfEmptyEvt & extMode & intCtrl_ff[`AEM_IC_HALF_IRQ]));

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irqLine5 <= 1'b0;
      irqLine7 <= 1'b0;
      irqLine10 <= 1'b0;
      irqLineOther <= 1'b0;
    end else begin
      // R10 line select
      irqLine5 <= irqPending & (intCtrl_ff[3:0] == `AEM_SEL_A);
      irqLine7 <= irqPending & (intCtrl_ff[3:0] == `AEM_SEL_B);
      irqLine10 <= irqPending & (intCtrl_ff[3:0] == `AEM_SEL_C);
      irqLineOther <= irqPending & (intCtrl_ff[3:0] == `AEM_SEL_OTHER);
    end
  end

  // ****************************************
  // synthesizer index and data ports
  // ****************************************
  // R22 two banks of registers
  always @(posedge clk_sys) begin
    // R19 data write to indexed register
    if (hostWr && (hostAddr == `AEM_PORT_SYN_DAT0 ||
        hostAddr == `AEM_PORT_SYN_DAT1)) begin
      synMem[{synBank_ff, synIdx_ff}] <= hostWrData;
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      synIdx_ff <= 8'h00;
      synBank_ff <= 1'b0;
      synStatus_ff <= `AEM_SYN_STATUS_RST;
    end else begin
      // R20 index retained
      if (hostWr && hostAddr == `AEM_PORT_SYN_IDX0) begin
        synIdx_ff <= hostWrData;
        synBank_ff <= 1'b0;
      end else if (hostWr && hostAddr == `AEM_PORT_SYN_IDX1) begin
        synIdx_ff <= hostWrData;
        synBank_ff <= 1'b1;
      end
      synStatus_ff <= `AEM_SYN_STATUS_RST;
    end
  end

  // ****************************************
  // host read data and decoded outputs
  // ****************************************
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      hostRdData <= 8'h00;
      pbData <= 8'h00;
      pbValid <= 1'b0;
      monoMode <= 1'b0;
      stereoMode <= 1'b0;
      recMonitor <= 1'b0;
      gainLeft <= 4'h0;
      gainRight <= 4'h0;
      pbUnsigned <= 1'b0;
      fmtStereo <= 1'b0;
      fmtWide <= 1'b0;
      fmtSigned <= 1'b0;
      synStatusOut <= 8'h00;
    end else begin
      // R21 only status readable
      if (hostRd) begin
        if (hostAddr == `AEM_PORT_SYN_IDX0) begin
          hostRdData <= synStatus_ff;
        end else if (hostAddr == `AEM_PORT_READ_DATA) begin
          hostRdData <= readBack_ff;
        end else if (hostAddr == `AEM_PORT_READ_STATUS) begin
          hostRdData <= {readAvail_ff, 7'h00};
        end else begin
          hostRdData <= 8'h00;
        end
      end
      if (fifoPop) begin
        pbValid <= fifoOutValid;
        pbData <= fifoOutData;
      end
      // R4 program type decode
      monoMode <= (progType_ff[1:0] == `AEM_PT_MONO);
      stereoMode <= (progType_ff[1:0] == `AEM_PT_STEREO);
      // R5 record monitor
      recMonitor <= progType_ff[`AEM_PT_MONITOR];
      // R15 gain nibbles
      gainLeft <= inGain_ff[3:0];
      gainRight <= inGain_ff[7:4];
      pbUnsigned <= pbInit_ff[7];
      // R18 format byte decode
      fmtStereo <= fmtByte_ff[`AEM_FMT_STEREO];
      fmtWide <= fmtByte_ff[`AEM_FMT_WIDE];
      fmtSigned <= fmtByte_ff[`AEM_FMT_SIGNED];
      synStatusOut <= synStatus_ff;
    end
  end
endmodule

/* test/aem_bank_monitor.sv */
/*
 * checker for the register bank: decode, request gating, interrupt
 * routing and read-back relations seen at the ports.
 * assumes binding to aem_register_bank, one clock domain.
 */
`timescale 1ns/100ps
module aem_bank_monitor (
  // clock and reset
  input wire clk_sys,
  input wire reset_n,
  // host port
  input wire [11:0] hostAddr,
  input wire hostWr,
  input wire hostRd,
  input wire [7:0] hostWrData,
  input wire [7:0] hostRdData,
  // dma and interrupt
  input wire extMode,
  input wire halfEmptyEvt,
  input wire dmaReq,
  input wire irqLine5,
  input wire irqLine7,
  input wire irqLine10,
  input wire irqLineOther,
  // decoded configuration
  input wire monoMode,
  input wire stereoMode,
  input wire recMonitor,
  input wire [3:0] gainLeft,
  input wire [3:0] gainRight,
  input wire pbUnsigned,
  input wire fmtStereo,
  input wire fmtWide,
  input wire fmtSigned,
  input wire [7:0] synStatusOut
);
  // ****************************************
  // command port tracking
  // ****************************************
  reg [1:0] phase_ff;
  reg [7:0] regNum_ff;
  reg [7:0] lastData_ff;
  reg [7:0] intCtrl_ff;
  reg [7:0] dmaCtrl_ff;
  reg fmtSecond_ff;
  wire cmdWr = hostWr && hostAddr == 12'h00C;
  wire dataWr = cmdWr && phase_ff == 2'h1;
  wire reqGate = extMode ? dmaCtrl_ff[6] : dmaCtrl_ff[5];
  wire rt5 = intCtrl_ff[7] && intCtrl_ff[4] && intCtrl_ff[3:0] == 4'h5;
  wire heOk = rt5 && intCtrl_ff[5] && extMode;

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      phase_ff <= 2'h0;
      regNum_ff <= 8'h00;
      lastData_ff <= 8'h00;
      intCtrl_ff <= 8'h05;
      dmaCtrl_ff <= 8'h00;
      fmtSecond_ff <= 1'h0;
    end else if (cmdWr) begin
      // read command consumes the following number
      if (phase_ff == 2'h0) begin
        phase_ff <= hostWrData == 8'hC0 ? 2'h2 : 2'h1;
        regNum_ff <= hostWrData;
      end else begin
        phase_ff <= 2'h0;
      end
      if (dataWr) begin
        lastData_ff <= hostWrData;
        if (regNum_ff == 8'hB1) intCtrl_ff <= hostWrData;
        if (regNum_ff == 8'hB2) dmaCtrl_ff <= hostWrData;
        if (regNum_ff == 8'hB7) fmtSecond_ff <= ~fmtSecond_ff;
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking mcb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  gain_map_a: assert property (
    dataWr && regNum_ff == 8'hB4 |-> ##2 {gainRight, gainLeft} == lastData_ff)
    else $error("gain nibbles wrong");
  prog_type_a: assert property (
    dataWr && regNum_ff == 8'hA8 |-> ##2
    monoMode == (lastData_ff[1:0] == 2'h2) && recMonitor == lastData_ff[3]
    && stereoMode == (lastData_ff[1:0] == 2'h1))
    else $error("program type decode wrong");
  pb_sign_a: assert property (
    dataWr && regNum_ff == 8'hB6 |-> ##2 pbUnsigned == lastData_ff[7])
    else $error("playback sign wrong");
  fmt_decode_a: assert property (
    dataWr && regNum_ff == 8'hB7 && fmtSecond_ff |-> ##2
    {fmtStereo, fmtWide, fmtSigned} == {lastData_ff[3:2], lastData_ff[5]})
    else $error("format decode wrong");
  req_gate_a: assert property (
    dmaReq |-> $past(reqGate))
    else $error("request without enable");
  irq_route_a: assert property (
    irqLine5 |-> $past(rt5))
    else $error("line 5 pulse not allowed");
  half_empty_a: assert property (
    halfEmptyEvt && heOk |=> irqLine5)
    else $error("half empty pulse missing");
  irq_single_a: assert property (
    $onehot0({irqLine5, irqLine7, irqLine10, irqLineOther}))
    else $error("more than one line");
  synth_wo_a: assert property (
    hostRd && hostAddr inside {12'h389, 12'h38A, 12'h38B}
    |=> hostRdData == 8'h00)
    else $error("write-only port read nonzero");

  cover property (dataWr && regNum_ff == 8'hB7 && fmtSecond_ff);
  cover property (irqLine5 ##1 !irqLine5);
  cover property ($rose(dmaReq));
endmodule

/* test/aem_dma_host.sv */
/*
 * dma controller model: acknowledges requested bytes with a rising
 * byte sequence, promptly or every other cycle.
 * assumes the bank's clock; drives on the falling edge.
 */
`timescale 1ns/100ps
module aem_dma_host (
  // clock and reset
  input wire clk_sys,
  input wire reset_n,
  // dma handshake
  input wire dmaReq,
  input wire slow,
  output reg dmaAck,
  output reg [7:0] dmaData
);
  reg [7:0] seq;
  reg gap;
  initial begin
    dmaAck = 1'h0;
    dmaData = 8'hFF;
    seq = 8'h00;
    gap = 1'h0;
  end
  // idle data line keeps changing so nothing stale looks valid
  always @(negedge clk_sys) begin
    gap <= ~gap;
    if (reset_n && dmaReq && (!slow || gap)) begin
      dmaAck <= 1'h1;
      dmaData <= seq;
      seq <= seq + 8'h01;
    end else begin
      dmaAck <= 1'h0;
      dmaData <= ~dmaData;
    end
  end
endmodule

/* test/aem_register_bank_test.sv */
/*
 * bench for the register bank: host port tasks, read-back, decode,
 * synthesizer ports, interrupt routing and fifo fill and drain.
 * assumes the dma model beside the bank and the checker bound in.
 */
`timescale 1ns/100ps
module aem_register_bank_test;
  reg clk_sys, reset_n, hostWr, hostRd, extMode, pbReady;
  reg halfEmptyEvt, slow;
  reg [11:0] hostAddr;
  reg [7:0] hostWrData, v, last;
  reg [15:0] ent;
  wire [7:0] hostRdData, dmaData, pbData, synStatusOut;
  wire dmaAck, dmaReq, pbValid, irqLine5, irqLine7, irqLine10;
  wire irqLineOther, monoMode, stereoMode, recMonitor, pbUnsigned;
  wire fmtStereo, fmtWide, fmtSigned;
  wire [3:0] gainLeft, gainRight;
  wire [3:0] irqVec = {irqLineOther, irqLine10, irqLine7, irqLine5};
  integer error_cnt, total_checks, i, k, c, n[4];
  reg [63:0] fmtTab = 64'hBC9C_B898_F4D4_F0D0;
  // per entry: control, expected line mask, mode, slow partner
  reg [143:0] tab =
    144'hD510_D302_D082_DF42_DA23_5502_C502_9502_D512;

  aem_register_bank dut_u (.clk_sys(clk_sys), .reset_n(reset_n),
    .hostAddr(hostAddr), .hostWr(hostWr), .hostRd(hostRd),
    .hostWrData(hostWrData), .hostRdData(hostRdData),
    .extMode(extMode), .dmaAck(dmaAck), .dmaData(dmaData),
    .dmaReq(dmaReq), .pbData(pbData), .pbValid(pbValid),
    .pbReady(pbReady), .halfEmptyEvt(halfEmptyEvt),
    .irqLine5(irqLine5), .irqLine7(irqLine7), .irqLine10(irqLine10),
    .irqLineOther(irqLineOther), .monoMode(monoMode),
    .stereoMode(stereoMode), .recMonitor(recMonitor),
    .gainLeft(gainLeft), .gainRight(gainRight),
    .pbUnsigned(pbUnsigned), .fmtStereo(fmtStereo), .fmtWide(fmtWide),
    .fmtSigned(fmtSigned), .synStatusOut(synStatusOut));
  aem_dma_host host_u (.clk_sys(clk_sys), .reset_n(reset_n),
    .dmaReq(dmaReq), .slow(slow), .dmaAck(dmaAck), .dmaData(dmaData));

  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end

  task chk(input [15:0] seen, input [15:0] exp, input string nm);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("CHECK FAILED %0s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task summarize;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task pWr(input [11:0] a, input [7:0] d);
    @(negedge clk_sys);
    hostAddr = a;
    hostWrData = d;
    hostWr = 1'h1;
    @(negedge clk_sys);
    hostWr = 1'h0;
  endtask

  task pRd(input [11:0] a);
    @(negedge clk_sys);
    hostAddr = a;
    hostRd = 1'h1;
    @(negedge clk_sys);
    hostRd = 1'h0;
    v = hostRdData;
  endtask

  task regWr(input [7:0] r, input [7:0] d);
    pWr(12'h00C, r);
    pWr(12'h00C, d);
    @(negedge clk_sys);
  endtask

  task regRd(input [7:0] r, input [7:0] e);
    integer t;
    pWr(12'h00C, 8'hC0);
    pWr(12'h00C, r);
    v = 8'h00;
    for (t = 0; t < 8 && v[7] !== 1'h1; t = t + 1) pRd(12'h00E);
    chk(v[7], 1'h1, "read ready");
    pRd(12'h00A);
    chk(v, e, "ext read");
  endtask

  task heTry(input x, input [7:0] ic, input e);
    regWr(8'hB1, ic);
    extMode = x;
    halfEmptyEvt = 1'h1;
    @(negedge clk_sys);
    halfEmptyEvt = 1'h0;
    chk(irqLine5, e, "half empty irq");
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt = error_cnt + 1;
    summarize;
  end

  initial begin
    {hostWr, hostRd, extMode, pbReady, halfEmptyEvt, slow} = 6'h00;
    hostAddr = 12'h000;
    hostWrData = 8'h00;
    error_cnt = 0;
    total_checks = 0;
    reset_n = 1'h0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    reset_n = 1'h1;
    regRd(8'hB1, 8'h05);
    regWr(8'hA4, 8'h12);
    regWr(8'hA5, 8'h34);
    regRd(8'hA4, 8'h12);
    regRd(8'hA5, 8'h34);
    regWr(8'hB2, 8'h0F);
    regRd(8'hB2, 8'h05);
    regWr(8'hA8, 8'hFA);
    regRd(8'hA8, 8'h0A);
    chk({monoMode, stereoMode, recMonitor}, 3'h5, "prog type");
    regWr(8'hA8, 8'h01);
    chk({monoMode, stereoMode, recMonitor}, 3'h2, "prog type");
    regWr(8'hB4, 8'h3C);
    chk({gainRight, gainLeft}, 8'h3C, "gain");
    pRd(12'h00E);
    chk(v[7], 1'h0, "ready cleared");
    pWr(12'h388, 8'h04);
    pWr(12'h389, 8'h21);
    pWr(12'h389, 8'h22);
    for (k = 0; k < 5; k = k + 1) begin
      pRd(k == 4 ? 12'h123 : 12'h388 + k[11:0]);
      chk(v, 8'h00, "port read");
    end
    chk(synStatusOut, 8'h00, "synth status");
    for (k = 0; k < 8; k = k + 1) begin
      regWr(8'hB6, k[0] ? 8'h00 : 8'h80);
      regWr(8'hB7, k[0] ? 8'h71 : 8'h51);
      regWr(8'hB7, fmtTab[8*k +: 8]);
      chk({fmtStereo, fmtWide, fmtSigned, pbUnsigned},
        {k[2:0], ~k[0]}, "format");
    end
    regWr(8'hB2, 8'h40);
    repeat (3) @(negedge clk_sys);
    chk(dmaReq, 1'h0, "dma req");
    regWr(8'hB2, 8'h00);
    extMode = 1'h1;
    regWr(8'hB2, 8'h20);
    repeat (3) @(negedge clk_sys);
    chk(dmaReq, 1'h0, "dma req");
    regWr(8'hB2, 8'h00);
    heTry(1'h1, 8'hB5, 1'h1);
    heTry(1'h0, 8'hB5, 1'h0);
    heTry(1'h1, 8'hA5, 1'h0);
    heTry(1'h1, 8'h35, 1'h0);
    // overflow every third byte after loading FFFD
    for (i = 0; i < 9; i = i + 1) begin
      ent = tab[16*i +: 16];
      regWr(8'hB1, ent[15:8]);
      regWr(8'hA4, 8'hFD);
      regWr(8'hA5, 8'hFF);
      extMode = ent[1];
      slow = ent[0];
      for (k = 0; k < 4; k = k + 1) n[k] = 0;
      regWr(8'hB2, ent[1] ? 8'h40 : 8'h20);
      repeat (48) begin
        @(negedge clk_sys);
        for (k = 0; k < 4; k = k + 1) n[k] = n[k] + irqVec[k];
      end
      chk(dmaReq, 1'h0, "full refuses");
      for (k = 0; k < 4; k = k + 1) begin
        chk(n[k], ent[4+k] ? 5 : 0, "irq count");
      end
      regWr(8'hB2, 8'h00);
      c = 0;
      repeat (24) begin
        @(negedge clk_sys);
        if (pbValid === 1'h1) begin
          v = last + 8'h01;
          if (c > 0) chk(pbData, v, "fifo order");
          last = pbData;
          c = c + 1;
        end
        pbReady = 1'h1;
      end
      pbReady = 1'h0;
      // sixteen fifo words plus the one held in the output stage
      chk(c, 17, "drained");
      chk(pbValid, 1'h0, "empty");
    end
    summarize;
  end
endmodule

bind aem_register_bank aem_bank_monitor mon_u (.clk_sys(clk_sys),
  .reset_n(reset_n), .hostAddr(hostAddr), .hostWr(hostWr),
  .hostRd(hostRd), .hostWrData(hostWrData), .hostRdData(hostRdData),
  .extMode(extMode), .halfEmptyEvt(halfEmptyEvt), .dmaReq(dmaReq),
  .irqLine5(irqLine5), .irqLine7(irqLine7), .irqLine10(irqLine10),
  .irqLineOther(irqLineOther), .monoMode(monoMode),
  .stereoMode(stereoMode), .recMonitor(recMonitor),
  .gainLeft(gainLeft), .gainRight(gainRight), .pbUnsigned(pbUnsigned),
  .fmtStereo(fmtStereo), .fmtWide(fmtWide), .fmtSigned(fmtSigned),
  .synStatusOut(synStatusOut));
